/* File: rtl/fault_pkg.sv */
package fault_pkg;
    localparam int          DATA_W           = 8;
    localparam int          ADDR_W           = 8;
    localparam int          CFG_W            = 3;

    // register offsets
    localparam logic [7:0]  ACC_FAULT_ADDR   = 8'h6d;
    localparam logic [7:0]  OUT_CFG_ADDR     = 8'h75;
    localparam logic [7:0]  LIVE_FAULT_ADDR  = 8'h7c;
    localparam logic [7:0]  CLEAR_CTRL_ADDR  = 8'h2d;

    // reset values
    localparam logic [7:0]  FAULT_RESET      = 8'h00;
    localparam logic [7:0]  OUT_CFG_RESET    = 8'h00;
    localparam logic [7:0]  CLEAR_CTRL_RESET = 8'h30;
    localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;

    // fault vector bit positions
    localparam int          BIT_CFLY_OV      = 0;
    localparam int          BIT_OVER_CURRENT = 1;
    localparam int          BIT_PLL          = 2;
    localparam int          BIT_SUPPLY_UV    = 3;
    localparam int          BIT_OT_WARNING   = 4;
    localparam int          BIT_OT_ERROR     = 5;
    localparam int          BIT_PIN_SHORT    = 6;
    localparam int          BIT_DC           = 7;

    // clear control field position
    localparam int          BIT_LATCH_CLEAR  = 2;

    typedef enum logic [1:0] {
        CLR_ARMED_LOW,
        CLR_SEEN_HIGH
    } clear_state_e;
endpackage : fault_pkg

/* File: rtl/fault_if.sv */
`timescale 1ns/10ps
interface fault_if;
    logic [fault_pkg::DATA_W-1:0] live;
    logic                         clear;
    logic [fault_pkg::DATA_W-1:0] acc;

    modport ctrl  (output live, output clear, input acc);
    modport accum (input live, input clear, output acc);
endinterface : fault_if

/* File: rtl/fault_accumulator.sv */
`timescale 1ns/10ps
module fault_accumulator (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    fault_if.accum    flt
);
    logic [fault_pkg::DATA_W-1:0] acc_r;
    logic [fault_pkg::DATA_W-1:0] acc_nxt;

    // set wins over a clear in the same cycle
    always_comb begin
        acc_nxt = flt.clear ? flt.live : (acc_r | flt.live);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= fault_pkg::FAULT_RESET;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign flt.acc = acc_r;
endmodule : fault_accumulator

/* File: rtl/fault_status_monitor.sv */
`timescale 1ns/10ps
// Overview of operation
// - live fault register follows sources, unlatched
// - accumulated fault bits stay set until a clear
// - bits 0-3: cfly ov, overcurrent, pll, undervoltage
// - bits 4-7: ot warn, ot error, short, dc
// - fault bits one when triggered, reset zero
// - output configuration pins shown in three bits
// - low-high-low toggle of clear control clears
module fault_status_monitor (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,

    // protection sources, active high
    input  wire logic       cfly_ov_fault,
    input  wire logic       over_current_fault,
    input  wire logic       pll_fault,
    input  wire logic       power_stage_supply_uv,
    input  wire logic       ot_warning,
    input  wire logic       ot_error,
    input  wire logic       pin_short_fault,
    input  wire logic       dc_fault,

    // output configuration strap
    input  wire logic [2:0] out_cfg_sel,

    // register port requests
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,

    // register port answers
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,

    // clear event
    output logic            fault_latch_clear
);

    // carrier between the control side and the accumulator
    fault_if flt ();

    // live and mirrored pin state
    logic [fault_pkg::DATA_W-1:0] live_r;
    logic [fault_pkg::DATA_W-1:0] src_vec;
    logic [fault_pkg::CFG_W-1:0]  out_cfg_r;

    // clear control path
    logic [fault_pkg::DATA_W-1:0] clear_ctrl_r;
    logic                         clear_wr;
    logic                         clear_pulse_r;
    fault_pkg::clear_state_e      clr_state_r;

    // read port
    logic [fault_pkg::DATA_W-1:0] rdata_r;
    logic [fault_pkg::DATA_W-1:0] rdata_nxt;
    logic                         rvalid_r;

    // read data select for every mapped offset
    function automatic logic [fault_pkg::DATA_W-1:0] read_mux(
        input logic [fault_pkg::ADDR_W-1:0] addr,
        input logic [fault_pkg::DATA_W-1:0] live,
        input logic [fault_pkg::DATA_W-1:0] acc,
        input logic [fault_pkg::CFG_W-1:0]  cfg,
        input logic [fault_pkg::DATA_W-1:0] clr
    );
        logic [fault_pkg::DATA_W-1:0] d;

        d = fault_pkg::UNMAPPED_DATA;

        // unmapped offsets read as zero
        case (addr)
            fault_pkg::LIVE_FAULT_ADDR: begin
                d = live;
            end

            fault_pkg::ACC_FAULT_ADDR: begin
                d = acc;
            end

            fault_pkg::OUT_CFG_ADDR: begin
                d = {{(fault_pkg::DATA_W-fault_pkg::CFG_W){1'b0}}, cfg};
            end

            fault_pkg::CLEAR_CTRL_ADDR: begin
                d = clr;
            end

            default: begin
                d = fault_pkg::UNMAPPED_DATA;
            end
        endcase

        return d;
    endfunction : read_mux

    // one source per bit position
    always_comb begin
        src_vec                               = fault_pkg::FAULT_RESET;

        // bits 0 to 3
        src_vec[fault_pkg::BIT_CFLY_OV]       = cfly_ov_fault;
        src_vec[fault_pkg::BIT_OVER_CURRENT]  = over_current_fault;
        src_vec[fault_pkg::BIT_PLL]           = pll_fault;
        src_vec[fault_pkg::BIT_SUPPLY_UV]     = power_stage_supply_uv;

        // bits 4 to 7
        src_vec[fault_pkg::BIT_OT_WARNING]    = ot_warning;
        src_vec[fault_pkg::BIT_OT_ERROR]      = ot_error;
        src_vec[fault_pkg::BIT_PIN_SHORT]     = pin_short_fault;
        src_vec[fault_pkg::BIT_DC]            = dc_fault;
    end

    // live vector, refreshed every cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            live_r <= fault_pkg::FAULT_RESET;
        end else begin
            live_r <= src_vec;
        end
    end

    // output configuration mirror
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_cfg_r <= fault_pkg::OUT_CFG_RESET[fault_pkg::CFG_W-1:0];
        end else begin
            out_cfg_r <= out_cfg_sel;
        end
    end

    // write strobe aimed at the clear control offset
    always_comb begin
        clear_wr = reg_wr && (reg_addr == fault_pkg::CLEAR_CTRL_ADDR);
    end

    // clear control register; monitor offsets take no write
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clear_ctrl_r <= fault_pkg::CLEAR_CTRL_RESET;
        end else if (clear_wr) begin
            clear_ctrl_r <= reg_wdata;
        end
    end

    // toggle detector on the clear field
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_state_r   <= fault_pkg::CLR_ARMED_LOW;
            clear_pulse_r <= 1'b0;
        end else begin
            clear_pulse_r <= 1'b0;

            case (clr_state_r)
                fault_pkg::CLR_ARMED_LOW: begin
                    if (clear_ctrl_r[fault_pkg::BIT_LATCH_CLEAR]) begin
                        clr_state_r <= fault_pkg::CLR_SEEN_HIGH;
                    end else begin
                        clr_state_r <= fault_pkg::CLR_ARMED_LOW;
                    end
                end

                fault_pkg::CLR_SEEN_HIGH: begin
                    if (!clear_ctrl_r[fault_pkg::BIT_LATCH_CLEAR]) begin
                        clr_state_r   <= fault_pkg::CLR_ARMED_LOW;
                        clear_pulse_r <= 1'b1;
                    end else begin
                        clr_state_r <= fault_pkg::CLR_SEEN_HIGH;
                    end
                end

                default: begin
                    clr_state_r <= fault_pkg::CLR_ARMED_LOW;
                end
            endcase
        end
    end

    // interface drive towards the accumulator
    assign flt.live  = live_r;
    assign flt.clear = clear_pulse_r;

    // sticky accumulator
    fault_accumulator u_accum (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .flt     (flt)
    );

    // read mux, decoded from the present address
    always_comb begin
        rdata_nxt = read_mux(reg_addr, live_r, flt.acc, out_cfg_r, clear_ctrl_r);
    end

    // read data register, held until the next read
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= fault_pkg::UNMAPPED_DATA;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // answer flag, one cycle after each read strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
        end
    end

    // outputs, each straight from a flip-flop
    assign reg_rdata         = rdata_r;
    assign reg_rvalid        = rvalid_r;
    assign fault_latch_clear = clear_pulse_r;
endmodule : fault_status_monitor

/* File: test/fault_chk.sv */
`timescale 1ns/10ps
module fault_chk (
    input wire logic       ref_clk, rst_b, cfly_ov_fault, over_current_fault, pll_fault, power_stage_supply_uv,
    input wire logic       ot_warning, ot_error, pin_short_fault, dc_fault, reg_wr, reg_rd, reg_rvalid,
    input wire logic       fault_latch_clear,
    input wire logic [2:0] out_cfg_sel,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
    wire [7:0] v = {dc_fault, pin_short_fault, ot_error, ot_warning, power_stage_supply_uv, pll_fault,
                    over_current_fault, cfly_ov_fault};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence rd_at(a);
        reg_rd && reg_addr == a;
    endsequence
    a_rd_valid: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_idle_quiet: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
        else $error("answer without read");
    a_live_value: assert property (rd_at(8'h7c) |=> reg_rdata == $past(v, 2))
        else $error("live flags wrong");
    a_cfg_value: assert property (rd_at(8'h75) |=> reg_rdata == {5'b0, $past(out_cfg_sel, 2)})
        else $error("config mirror wrong");
    a_acc_sticky: assert property (rd_at(8'h6d) |=> (reg_rdata & $past(v, 3)) == $past(v, 3))
        else $error("sticky bit lost");
    a_clr_pulse: assert property (fault_latch_clear |=> !fault_latch_clear)
        else $error("clear pulse too long");
    a_clr_cause: assert property (fault_latch_clear |-> $past(reg_wr && reg_addr == 8'h2d && !reg_wdata[2], 2))
        else $error("clear pulse without toggle");
    a_clr_reload: assert property (fault_latch_clear ##1 rd_at(8'h6d) |=> reg_rdata == $past(v, 3))
        else $error("sticky flags not cleared");
endmodule : fault_chk
bind fault_status_monitor fault_chk chk (.ref_clk, .rst_b, .cfly_ov_fault, .over_current_fault, .pll_fault,
    .power_stage_supply_uv, .ot_warning, .ot_error, .pin_short_fault, .dc_fault, .reg_wr, .reg_rd, .reg_rvalid,
    .fault_latch_clear, .out_cfg_sel, .reg_addr, .reg_wdata, .reg_rdata);

/* File: test/host_model.sv */
`timescale 1ns/10ps
module host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd
);
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : get
    task automatic clear();
        put(8'h2d, 8'h34);
        put(8'h2d, 8'h30);
    endtask : clear
endmodule : host_model

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
    logic       ref_clk, rst_b, wr, rd, rvalid, clr;
    logic [7:0] src, addr, wdata, rdata, got;
    logic [2:0] sel;
    int         fails, num_checks;
    host_model host (.ref_clk, .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd));
    fault_status_monitor DUT (.ref_clk, .rst_b, .cfly_ov_fault(src[0]), .over_current_fault(src[1]),
        .pll_fault(src[2]), .power_stage_supply_uv(src[3]), .ot_warning(src[4]), .ot_error(src[5]),
        .pin_short_fault(src[6]), .dc_fault(src[7]), .out_cfg_sel(sel), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .fault_latch_clear(clr));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        host.get(a, got);
        check(what, got, exp);
    endtask : rd_chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic t_reset();
        rd_chk(8'h6d, 8'h00, "sticky reset");
        rd_chk(8'h75, 8'h00, "config reset");
        rd_chk(8'h7c, 8'h00, "live reset");
        rd_chk(8'h2d, 8'h30, "clear control reset");
        rd_chk(8'h10, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_cfg();
        for (int i = 0; i < 8; i++) begin
            sel = i[2:0];
            rd_chk(8'h75, {5'b0, i[2:0]}, "config mirror");
        end
    endtask : t_cfg
    task automatic t_sources();
        for (int i = 0; i < 8; i++) begin
            src = 8'h01 << i;
            rd_chk(8'h7c, 8'h01 << i, "live bit");
            src = 8'h00;
            rd_chk(8'h7c, 8'h00, "live after fault");
            rd_chk(8'h6d, 8'((16'h0002 << i) - 16'h0001), "sticky bits");
        end
    endtask : t_sources
    task automatic t_ignore();
        host.put(8'h6d, 8'h00);
        host.put(8'h75, 8'hff);
        host.put(8'h7c, 8'hff);
        rd_chk(8'h6d, 8'hff, "sticky after write");
        rd_chk(8'h75, {5'b0, sel}, "config after write");
        rd_chk(8'h7c, 8'h00, "live after write");
    endtask : t_ignore
    task automatic t_clear();
        for (int p = 0; p < 2; p++) begin
            src = (p == 0) ? 8'h80 : 8'h00;
            host.clear();
            for (int n = 0; n < 8 && clr !== 1'b1; n++) @(posedge ref_clk) #1;
            check("clear pulse", {7'b0, clr}, 8'h01);
            rd_chk(8'h6d, src, "sticky after clear");
        end
    endtask : t_clear
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    initial begin
        rst_b = 1'b0;
        src = 8'h00;
        sel = 3'h0;
        repeat (10) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        t_reset();
        t_cfg();
        t_sources();
        t_ignore();
        t_clear();
        complete_run();
    end
endmodule : tb
